// ### hdl/mdal_map.svh
// register offsets, field positions and reset values of the alarm block
`ifndef MDAL_MAP_SVH
`define MDAL_MAP_SVH
`define MDAL_OFF_CTRL 12'h000
`define MDAL_OFF_STAT 12'h004
`define MDAL_OFF_SPDLIM 12'h008
`define MDAL_OFF_CMD 12'h00C
`define MDAL_OFF_IRQ 12'h010
`define MDAL_OFF_MASK 12'h014
`define MDAL_OFF_HIST0 12'h040
`define MDAL_HIST_DEPTH 10
`define MDAL_CTRL_RST 32'h0000_0000
`define MDAL_UPPER_RST 16'hFFFF
`define MDAL_LOWER_RST 16'h0000
`define MDAL_CTRL_3WIRE 0
`define MDAL_CTRL_DIR 1
`define MDAL_CTRL_BRKSEL 2
`define MDAL_CTRL_EDITEN 3
`define MDAL_CTRL_LOCK 4
`define MDAL_CTRL_SWLINK 5
`define MDAL_CMD_PANELCLR 0
`define MDAL_CMD_LINKCLR 1
`define MDAL_CMD_HISTCLR 2
`define MDAL_IRQ_FAULT 0
`define MDAL_IRQ_REJECT 1
`define MDAL_IRQ_CLEARED 2
`define MDAL_BLINK_CYCLES 24'd2500000
`endif

// ### hdl/mdal_pkg.sv
// types of the motor driver alarm block
`default_nettype none
package mdal_pkg;
   typedef enum logic [1:0] {
      MDAL_NORMAL,
      MDAL_FAULT,
      MDAL_HARD
   } mdal_state_e;
   typedef struct packed {
      logic [3:0] code;
      logic hard;
   } mdal_fault_s;
   typedef struct packed {
      logic healthy;
      logic run;
      logic brake;
      logic led_red;
      logic led_orange;
      logic [3:0] code;
   } mdal_out_s;
endpackage
`default_nettype wire

// ### hdl/mdal_alarm.sv
// alarm latch, clear qualification, history and panel interlocks
//
// Decided for this implementation: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "mdal_map.svh"
module mdal_alarm (
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic hsel_in,
   input wire logic hready_in,
   input wire logic [31:0] hwdata_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   input wire mdal_pkg::mdal_fault_s fault_in,
   input wire logic fault_valid_in,
   input wire logic info_pending_in,
   input wire logic forward_run_input_in,
   input wire logic reverse_run_input_in,
   input wire logic fault_clear_in,
   input wire logic dial_step_in,
   input wire logic dial_up_in,
   input wire logic [15:0] speed_cmd_in,
   output var mdal_pkg::mdal_out_s status_out,
   output logic dir_cw_out,
   output logic [15:0] speed_out,
   output logic panel_error_out,
   output logic irq_out
);
   import mdal_pkg::*;

   mdal_state_e state_r;
   logic [31:0] ctrl_r;
   logic [15:0] upper_r, lower_r, dial_r;
   logic [2:0] irq_r, mask_r;
   logic [3:0] code_r;
   logic clr_d_r, panel_err_r, hist_clr_r;
   logic [23:0] blink_cnt_r;
   logic blink_r;
   // history lives in retained storage outside sys_rst_in
   logic [3:0] hist_mem [0:`MDAL_HIST_DEPTH-1];
   logic [3:0] hist_cnt_r;
   logic a_wr_r, a_rd_r;
   logic [11:0] a_addr_r;

   function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
                                         input logic [15:0] hi);
      clamp = (v > hi) ? hi : ((v < lo) ? lo : v);
   endfunction

   // bus address phase
   wire take = hsel_in && hready_in && htrans_in[1];
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         a_wr_r <= 1'b0;
         a_rd_r <= 1'b0;
         a_addr_r <= 12'h000;
      end else begin
         a_wr_r <= take && hwrite_in;
         a_rd_r <= take && !hwrite_in;
         a_addr_r <= haddr_in[11:0];
      end
   end

   wire wr_cmd = a_wr_r && (a_addr_r == `MDAL_OFF_CMD);
   wire link_on = ctrl_r[`MDAL_CTRL_SWLINK];
   wire runs_off = !forward_run_input_in && !reverse_run_input_in;
   wire clr_edge = fault_clear_in && !clr_d_r;
   // clear input gating by control mode
   wire clr_block = ctrl_r[`MDAL_CTRL_3WIRE] ?
      (forward_run_input_in && reverse_run_input_in) :
      (forward_run_input_in || reverse_run_input_in);
   wire panel_req = wr_cmd && hwdata_in[`MDAL_CMD_PANELCLR] && !link_on;
   wire panel_ok = panel_req && runs_off;
   wire link_req = wr_cmd && hwdata_in[`MDAL_CMD_LINKCLR];
   wire clr_any = (clr_edge && !clr_block) || panel_ok || link_req;
   wire new_fault = fault_valid_in;
   wire faulted = state_r != MDAL_NORMAL;

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         clr_d_r <= 1'b0;
      end else begin
         clr_d_r <= fault_clear_in;
      end
   end

   // alarm latch; power-up reset clears every state
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         state_r <= MDAL_NORMAL;
         code_r <= 4'h0;
      end else if (new_fault && state_r != MDAL_HARD) begin
         state_r <= fault_in.hard ? MDAL_HARD : MDAL_FAULT;
         code_r <= fault_in.code;
      end else if (state_r == MDAL_FAULT && clr_any) begin
         state_r <= MDAL_NORMAL;
         code_r <= 4'h0;
      end
      // hard state has no exit but reset
   end

   // panel rejection shown until next accepted clear
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         panel_err_r <= 1'b0;
      end else if (panel_req && !runs_off && faulted) begin
         panel_err_r <= 1'b1;
      end else if (clr_any) begin
         panel_err_r <= 1'b0;
      end
   end

   // configuration writes, frozen by fault or rejected clear
   wire cfg_ok = !faulted && !panel_err_r;
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         ctrl_r <= `MDAL_CTRL_RST;
         upper_r <= `MDAL_UPPER_RST;
         lower_r <= `MDAL_LOWER_RST;
      end else if (a_wr_r && cfg_ok) begin
         if (a_addr_r == `MDAL_OFF_CTRL) begin
            ctrl_r <= {26'h0000000, hwdata_in[5:0]};
         end
         if (a_addr_r == `MDAL_OFF_SPDLIM && !link_on) begin
            upper_r <= hwdata_in[31:16];
            lower_r <= hwdata_in[15:0];
         end
      end
   end

   // dial adjusts a local speed offset
   wire dial_ok = !ctrl_r[`MDAL_CTRL_LOCK] && ctrl_r[`MDAL_CTRL_EDITEN] && !link_on && cfg_ok;
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         dial_r <= 16'h0000;
      end else if (dial_step_in && dial_ok) begin
         dial_r <= dial_up_in ? dial_r + 16'h0001 : dial_r - 16'h0001;
      end
   end

   // history: shift newest in at entry 0, oldest falls off
   always_ff @(posedge clock_in) begin
      hist_clr_r <= wr_cmd && hwdata_in[`MDAL_CMD_HISTCLR] && !faulted;
      if (hist_clr_r) begin
         hist_cnt_r <= 4'h0;
      end else if (new_fault && state_r != MDAL_HARD) begin
         for (int i = `MDAL_HIST_DEPTH-1; i > 0; i--) begin
            hist_mem[i] <= hist_mem[i-1];
         end
         hist_mem[0] <= fault_in.code;
         if (hist_cnt_r != 4'(`MDAL_HIST_DEPTH)) begin
            hist_cnt_r <= hist_cnt_r + 4'h1;
         end
      end
   end

   // blink timebase
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         blink_cnt_r <= 24'h000000;
         blink_r <= 1'b0;
      end else if (blink_cnt_r == `MDAL_BLINK_CYCLES - 24'd1) begin
         blink_cnt_r <= 24'h000000;
         blink_r <= !blink_r;
      end else begin
         blink_cnt_r <= blink_cnt_r + 24'h000001;
      end
   end

   // outputs, all registered
   wire run_req = forward_run_input_in ^ reverse_run_input_in;
   // sum wraps at 16 bits; the clamp only sees the wrapped value
   wire [15:0] spd_sum = 16'(speed_cmd_in + dial_r);
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         status_out <= '0;
         dir_cw_out <= 1'b0;
         speed_out <= 16'h0000;
         panel_error_out <= 1'b0;
      end else begin
         status_out.healthy <= !faulted;
         status_out.run <= run_req && !faulted;
         status_out.brake <= faulted ? !ctrl_r[`MDAL_CTRL_BRKSEL] : !run_req;
         status_out.led_red <= faulted && blink_r;
         status_out.led_orange <= !faulted && info_pending_in && blink_r;
         status_out.code <= code_r;
         // positive runs cw when the setting is 1
         dir_cw_out <= ctrl_r[`MDAL_CTRL_DIR] ^ reverse_run_input_in;
         speed_out <= clamp(spd_sum, lower_r, upper_r);
         panel_error_out <= panel_err_r;
      end
   end

   // interrupt status, write one to clear, set wins
   wire [2:0] ev = {clr_any && state_r == MDAL_FAULT, panel_req && !runs_off && faulted,
                    new_fault && state_r != MDAL_HARD};
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         irq_r <= 3'h0;
         mask_r <= 3'h0;
         irq_out <= 1'b0;
      end else begin
         if (a_wr_r && a_addr_r == `MDAL_OFF_IRQ) begin
            irq_r <= (irq_r & ~hwdata_in[2:0]) | ev;
         end else begin
            irq_r <= irq_r | ev;
         end
         if (a_wr_r && a_addr_r == `MDAL_OFF_MASK) begin
            mask_r <= hwdata_in[2:0];
         end
         irq_out <= |(irq_r & mask_r);
      end
   end

   // read data in data phase, zero wait
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         hrdata_out <= 32'h0000_0000;
      end else if (take && !hwrite_in) begin
         hrdata_out <= 32'h0000_0000;
         unique case (haddr_in[11:0])
            `MDAL_OFF_CTRL: hrdata_out <= ctrl_r;
            `MDAL_OFF_STAT: hrdata_out <= {20'h00000, hist_cnt_r, code_r, 1'b0,
                                          panel_err_r, state_r};
            `MDAL_OFF_SPDLIM: hrdata_out <= {upper_r, lower_r};
            `MDAL_OFF_IRQ: hrdata_out <= {29'h0, irq_r};
            `MDAL_OFF_MASK: hrdata_out <= {29'h0, mask_r};
            default: begin
               if (haddr_in[11:6] == 6'h01 && haddr_in[5:2] < 4'(`MDAL_HIST_DEPTH) &&
                   {1'b0, haddr_in[5:2]} < {1'b0, hist_cnt_r}) begin
                  hrdata_out <= {28'h0, hist_mem[haddr_in[5:2]]};
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock_in) begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
   end

   hard_hold_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      state_r == MDAL_HARD |=> state_r == MDAL_HARD) else $error("hard fault left");
   healthy_drop_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      faulted |=> !status_out.healthy && !status_out.run) else $error("healthy while fault");
   level_clear_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      state_r == MDAL_FAULT && !new_fault && !clr_any |=> state_r == MDAL_FAULT)
      else $error("fault dropped without clear");
   blocked_clr_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      state_r == MDAL_FAULT && clr_edge && clr_block && !panel_ok && !link_req && !new_fault
      |=> state_r == MDAL_FAULT) else $error("blocked clear acted");
   edge_only_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      $rose(state_r == MDAL_NORMAL) && !$past(panel_ok) && !$past(link_req)
      |-> $past(fault_clear_in) && !$past(clr_d_r)) else $error("level clear");
   panel_rej_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      panel_req && !runs_off && faulted |=> panel_err_r ##1 panel_error_out)
      else $error("panel reject missed");
   cfg_frozen_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      faulted && !new_fault |=> $stable(ctrl_r)) else $error("config while fault");
   // limits written at the same edge reach the output one cycle later
   speed_clamp_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      lower_r <= upper_r |=> speed_out <= $past(upper_r) && speed_out >= $past(lower_r))
      else $error("speed out of range");
   run_one_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      forward_run_input_in == reverse_run_input_in |=> !status_out.run)
      else $error("run with bad inputs");
   brake_on_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      faulted && !ctrl_r[`MDAL_CTRL_BRKSEL] |=> status_out.brake) else $error("no brake");
endmodule // mdal_alarm
`default_nettype wire

// ### verif/mdal_ctrl_model.sv
// controller model driving the run and fault-clear inputs
`timescale 1ns/1ns
`default_nettype none
module mdal_ctrl_model (
   input wire logic clock_in,
   input wire logic fwd_req_in,
   input wire logic rev_req_in,
   input wire logic clear_req_in,
   input wire logic careful_in,
   output logic forward_run_input_out,
   output logic reverse_run_input_out,
   output logic fault_clear_out
);
   // careless mode keeps the runs on during a clear, used to provoke refusals and for the 3-wire clear with one run on
   always_ff @(posedge clock_in) begin
      if (clear_req_in && careful_in) begin
         forward_run_input_out <= 1'b0;
         reverse_run_input_out <= 1'b0;
         fault_clear_out <= !(forward_run_input_out || reverse_run_input_out);
      end else begin
         forward_run_input_out <= fwd_req_in;
         reverse_run_input_out <= rev_req_in;
         fault_clear_out <= clear_req_in;
      end
   end
endmodule // mdal_ctrl_model
`default_nettype wire

// ### verif/mdal_alarm_test.sv
// self-checking bench of the alarm block
`timescale 1ns/1ns
`default_nettype none
`include "mdal_map.svh"
module mdal_alarm_test;
   import mdal_pkg::*;
   logic clock_in, sys_rst_in, hwrite, fvalid, dstep, dup, forward_run_input, reverse_run_input, clr, careful, info;
   logic hready, hresp, dir_cw, perr, irq, fr, rr, fc;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, rdata;
   logic [15:0] scmd, spd;
   mdal_fault_s fault;
   mdal_out_s st;
   int n_errors, checks, cyc;
   logic [36:0] rows [6];
   mdal_alarm dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'b010), .hsel_in(1'b1),
      .hready_in(hready), .hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(hready),
      .hresp_out(hresp), .fault_in(fault), .fault_valid_in(fvalid), .info_pending_in(info),
      .forward_run_input_in(fr), .reverse_run_input_in(rr), .fault_clear_in(fc),
      .dial_step_in(dstep), .dial_up_in(dup), .speed_cmd_in(scmd), .status_out(st),
      .dir_cw_out(dir_cw), .speed_out(spd), .panel_error_out(perr), .irq_out(irq));
   mdal_ctrl_model partner (.clock_in(clock_in), .fwd_req_in(forward_run_input), .rev_req_in(reverse_run_input),
      .clear_req_in(clr), .careful_in(careful), .forward_run_input_out(fr),
      .reverse_run_input_out(rr), .fault_clear_out(fc));
   task conclude;
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock_in);
      haddr <= {20'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge clock_in); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clock_in); while (hready !== 1'b1);
      rdata = hrdata;
      chk(32'(hresp), 32'h0);
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
      repeat (2) @(posedge clock_in);
   endtask
   task rd(input logic [11:0] a);
      xfer(1'b0, a, 32'h0);
   endtask
   task flt(input logic [4:0] f);
      @(posedge clock_in);
      fault <= f;
      fvalid <= 1'b1;
      @(posedge clock_in);
      fvalid <= 1'b0;
      repeat (3) @(posedge clock_in);
   endtask
   task clear(input logic c);
      @(posedge clock_in);
      careful <= c;
      clr <= 1'b1;
      repeat (4) @(posedge clock_in);
      clr <= 1'b0;
      repeat (3) @(posedge clock_in);
   endtask
   task step;
      @(posedge clock_in);
      dstep <= 1'b1;
      @(posedge clock_in);
      dstep <= 1'b0;
      repeat (3) @(posedge clock_in);
   endtask
   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end
   // hang guard, well above the few hundred cycles the sequence needs
   always @(posedge clock_in) begin
      cyc++;
      if (cyc > 20000) begin
         n_errors++;
         conclude;
      end
   end
   initial begin
      sys_rst_in = 1'b1;
      {hwrite, fvalid, dstep, forward_run_input, reverse_run_input, clr} = 6'h00;
      {dup, careful, info} = 3'b111;
      htrans = 2'b00;
      haddr = 32'h0;
      hwdata = 32'h0;
      scmd = 16'h0000;
      fault = 5'h00;
      // dir, fwd, rev, speed command, run, cw, clamped speed
      rows[0] = {3'b010, 16'h0200, 2'b10, 16'h0100};
      rows[1] = {3'b001, 16'h0005, 2'b11, 16'h0010};
      rows[2] = {3'b110, 16'h0050, 2'b11, 16'h0050};
      rows[3] = {3'b101, 16'h0050, 2'b10, 16'h0050};
      rows[4] = {3'b011, 16'h0050, 2'b01, 16'h0050};
      rows[5] = {3'b100, 16'h0050, 2'b01, 16'h0050};
      repeat (10) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      wr(`MDAL_OFF_CMD, 32'h4);
      wr(`MDAL_OFF_SPDLIM, 32'h0100_0010);
      wr(`MDAL_OFF_MASK, 32'h0);
      for (int i = 0; i < 6; i++) begin
         forward_run_input <= rows[i][35];
         reverse_run_input <= rows[i][34];
         scmd <= rows[i][33:18];
         wr(`MDAL_OFF_CTRL, {30'h0, rows[i][36], 1'b0});
         chk(32'(st.run), 32'(rows[i][17]));
         chk(32'(dir_cw), 32'(rows[i][16]));
         chk(32'(spd), 32'(rows[i][15:0]));
      end
      forward_run_input <= 1'b1;
      scmd <= 16'h0050;
      wr(`MDAL_OFF_CTRL, 32'h00);
      step;
      chk(32'(spd), 32'h50);
      wr(`MDAL_OFF_CTRL, 32'h18);
      step;
      chk(32'(spd), 32'h50);
      wr(`MDAL_OFF_CTRL, 32'h08);
      step;
      chk(32'(spd > 16'h0050), 32'h1);
      wr(`MDAL_OFF_CTRL, 32'h20);
      wr(`MDAL_OFF_SPDLIM, 32'h1);
      rd(`MDAL_OFF_SPDLIM);
      chk(rdata, 32'h0100_0010);
      wr(`MDAL_OFF_CTRL, 32'h00);
      flt({4'h5, 1'b0});
      chk(32'({st.healthy, st.run, st.brake}), 32'h1);
      chk(32'(st.code), 32'h5);
      chk(32'(st.led_orange), 32'h0);
      chk(32'(irq), 32'h0);
      rd(`MDAL_OFF_IRQ);
      chk(rdata, 32'h1);
      wr(`MDAL_OFF_MASK, 32'h7);
      chk(32'(irq), 32'h1);
      wr(`MDAL_OFF_IRQ, 32'h1);
      chk(32'(irq), 32'h0);
      wr(`MDAL_OFF_CTRL, 32'h2);
      rd(`MDAL_OFF_CTRL);
      chk(rdata, 32'h0);
      clear(1'b0);
      chk(32'(st.healthy), 32'h0);
      // edge lands while a run is on, then the level stays with runs off
      @(posedge clock_in);
      careful <= 1'b0;
      clr <= 1'b1;
      repeat (3) @(posedge clock_in);
      forward_run_input <= 1'b0;
      repeat (5) @(posedge clock_in);
      chk(32'(st.healthy), 32'h0);
      clr <= 1'b0;
      forward_run_input <= 1'b1;
      repeat (3) @(posedge clock_in);
      clear(1'b1);
      chk(32'(st.healthy), 32'h1);
      rd(`MDAL_OFF_IRQ);
      chk(rdata, 32'h4);
      wr(`MDAL_OFF_IRQ, 32'h7);
      wr(`MDAL_OFF_CTRL, 32'h5);
      reverse_run_input <= 1'b1;
      flt({4'h3, 1'b0});
      chk(32'(st.brake), 32'h0);
      clear(1'b0);
      chk(32'(st.healthy), 32'h0);
      reverse_run_input <= 1'b0;
      clear(1'b0);
      chk(32'(st.healthy), 32'h1);
      wr(`MDAL_OFF_CTRL, 32'h0);
      flt({4'h9, 1'b0});
      wr(`MDAL_OFF_CMD, 32'h1);
      chk(32'({perr, st.healthy}), 32'h2);
      wr(`MDAL_OFF_CMD, 32'h2);
      chk(32'({perr, st.healthy}), 32'h1);
      rd(`MDAL_OFF_HIST0);
      chk(32'(rdata[3:0]), 32'h9);
      rd(`MDAL_OFF_HIST0 + 12'h4);
      chk(32'(rdata[3:0]), 32'h3);
      rd(`MDAL_OFF_STAT);
      chk(32'(rdata[11:8]), 32'h3);
      flt({4'hA, 1'b1});
      forward_run_input <= 1'b0;
      clear(1'b1);
      wr(`MDAL_OFF_CMD, 32'h1);
      wr(`MDAL_OFF_CMD, 32'h2);
      rd(`MDAL_OFF_STAT);
      chk(32'({st.healthy, rdata[1:0]}), 32'h2);
      sys_rst_in <= 1'b1;
      repeat (10) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      repeat (3) @(posedge clock_in);
      chk(32'(st.healthy), 32'h1);
      rd(`MDAL_OFF_STAT);
      chk(32'(rdata[11:8]), 32'h4);
      rd(`MDAL_OFF_HIST0);
      chk(32'(rdata[3:0]), 32'hA);
      wr(`MDAL_OFF_CMD, 32'h4);
      rd(`MDAL_OFF_STAT);
      chk(32'(rdata[11:8]), 32'h0);
      conclude;
   end
endmodule // mdal_alarm_test
`default_nettype wire
